// >>> hdl/rtr_tuning_registers.sv
// retimer tuning register bank: revision, receive equalizer and transmit edge rates
`timescale 1ns/1ps
// Functional notes
// - read-only revision byte at 0x08
// - chip reset release loads equalizer strap
// - 0x09 bits 3:2 clock lane equalizer
// - 0x09 bits 1:0 data lanes equalizer
// - strap-loaded fields stay software writable
// - 0x0A bits 7:6 side-A low-power slew
// - 0x0A bits 5:4 side-B slew, strap loaded
// - 0x0A bits 1:0 clock high-speed slew
// - offset pointer starts at zero, auto-increments
module rtr_tuning_registers #(
  parameter logic [7:0] SILICON_REVISION = 8'h00 // arbitrary value
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic chipResetN,
  input wire logic [1:0] eqStrapLevel,
  input wire logic [1:0] edgeStrapLevel,
  input wire logic [1:0] cfgStrapLevel,
  input wire logic offsetLoad,
  input wire logic [7:0] offsetIn,
  input wire logic byteWrite,
  input wire logic [7:0] writeData,
  input wire logic byteRead,
  output logic [7:0] readData,
  output logic readValid,
  output logic [1:0] clockLaneEqualizerLevel,
  output logic [1:0] dataLaneEqualizerLevel,
  output logic [1:0] sideALowpowerSlew,
  output logic [1:0] sideBLowpowerSlew,
  output logic [1:0] outputClockHighspeedSlew
);
  import rtr_pkg::*;

  // whole bank state
  typedef struct packed {
    rtr_phase_e phase; // where we are around the chip reset pin
    logic [7:0] ptr; // current sub-address
    logic [1:0] clkEq;
    logic [1:0] dataEq;
    logic [1:0] sideASlew;
    logic [1:0] sideBSlew;
    logic [1:0] hsClkSlew;
    logic [7:0] rdata; // last byte returned
    logic rvalid; // one-cycle read answer
  } rtr_state_s;

  rtr_state_s state_q;
  rtr_state_s state_d;

  logic [SYNC_WIDTH-1:0] pinStable; // synchronised pins
  logic chipResetHigh; // chip reset pin, released
  logic [1:0] eqStrap;
  logic [1:0] edgeStrap;
  logic [1:0] cfgStrap;
  logic accessOk; // register port is live
  logic [7:0] curByte; // register at the pointer

  // ----------------------------------------------------------------
  // strap decode and register read view functions
  // ----------------------------------------------------------------
  // three-level strap to equalizer code; mid maps to 2.5 dB, high to 5 dB
  function automatic logic [1:0] eqFromStrap(input logic [1:0] lvl);
    logic [1:0] code;
    code = EQ_0DB;
    if (lvl == STRAP_MID)
    begin
      code = EQ_2P5DB;
    end
    else if (lvl == STRAP_HIGH)
    begin
      code = EQ_5DB;
    end
    return code;
  endfunction

  // three-level strap to slew code; 2'h3 is never produced, so it stays software only
  function automatic logic [1:0] slewFromStrap(input logic [1:0] lvl);
    logic [1:0] code;
    code = HS_SLEW_200PS;
    if (lvl == STRAP_MID)
    begin
      code = HS_SLEW_150PS;
    end
    else if (lvl == STRAP_HIGH)
    begin
      code = HS_SLEW_250PS;
    end
    return code;
  endfunction

  // read view of one offset; unmapped offsets read as zero
  function automatic logic [7:0] regView(input logic [7:0] ofs, input rtr_state_s s);
    logic [7:0] v;
    v = BYTE_ZERO;
    case (ofs)
      OFS_SILICON_REVISION: v = SILICON_REVISION;
      OFS_RX_EQUALIZER:
      begin
        v[CLK_EQ_LSB +: 2] = s.clkEq;
        v[DATA_EQ_LSB +: 2] = s.dataEq;
      end
      OFS_TX_EDGE_RATE:
      begin
        v[SIDE_A_SLEW_LSB +: 2] = s.sideASlew;
        v[SIDE_B_SLEW_LSB +: 2] = s.sideBSlew;
        v[HS_CLK_SLEW_LSB +: 2] = s.hsClkSlew;
      end
      default: v = BYTE_ZERO;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // chip reset and straps come from pins, so one synchroniser covers all of them
  rtr_pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) pinSync (
    .mclk(mclk),
    .reset(reset),
    .pinIn({chipResetN, eqStrapLevel, edgeStrapLevel, cfgStrapLevel}),
    .pinStable(pinStable)
  );

  assign chipResetHigh = pinStable[6];
  assign eqStrap = pinStable[5:4];
  assign edgeStrap = pinStable[3:2];
  assign cfgStrap = pinStable[1:0];
  assign accessOk = (state_q.phase == PH_RUN) && chipResetHigh;
  assign curByte = regView(state_q.ptr, state_q);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    case (state_q.phase)
      // chip held in reset: fields at defaults, port closed
      PH_IN_RESET:
      begin
        state_d.clkEq = FIELD_RESET;
        state_d.dataEq = FIELD_RESET;
        state_d.sideASlew = FIELD_RESET;
        state_d.sideBSlew = FIELD_RESET;
        state_d.hsClkSlew = FIELD_RESET;
        state_d.ptr = PTR_RESET;
        if (chipResetHigh)
        begin
          state_d.phase = PH_LOAD;
        end
      end
      // single cycle after the release edge: straps taken exactly once
      PH_LOAD:
      begin
        state_d.clkEq = eqFromStrap(eqStrap);
        state_d.dataEq = eqFromStrap(eqStrap);
        state_d.sideASlew = LP_SLEW_18NS;
        state_d.sideBSlew = slewFromStrap(cfgStrap);
        state_d.hsClkSlew = slewFromStrap(edgeStrap);
        state_d.phase = chipResetHigh ? PH_RUN : PH_IN_RESET;
      end
      // normal operation; straps are no longer looked at
      PH_RUN:
      begin
        if (!chipResetHigh)
        begin
          state_d.phase = PH_IN_RESET;
        end
        else if (offsetLoad)
        begin
          // a sub-address write sets where the next read or write lands
          state_d.ptr = offsetIn;
        end
        else if (byteWrite)
        begin
          // software overwrites strap values freely; reserved bits dropped
          if (state_q.ptr == OFS_RX_EQUALIZER)
          begin
            state_d.clkEq = writeData[CLK_EQ_LSB +: 2];
            state_d.dataEq = writeData[DATA_EQ_LSB +: 2];
          end
          else if (state_q.ptr == OFS_TX_EDGE_RATE)
          begin
            state_d.sideASlew = writeData[SIDE_A_SLEW_LSB +: 2];
            state_d.sideBSlew = writeData[SIDE_B_SLEW_LSB +: 2];
            state_d.hsClkSlew = writeData[HS_CLK_SLEW_LSB +: 2];
          end
          state_d.ptr = state_q.ptr + 8'h01;
        end
        else if (byteRead)
        begin
          state_d.rdata = curByte;
          state_d.rvalid = 1'b1;
          state_d.ptr = state_q.ptr + 8'h01;
        end
      end
      default: state_d.phase = PH_IN_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= '0;
      state_q.phase <= PH_IN_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // analog settings and read answer straight from flops
  assign readData = state_q.rdata;
  assign readValid = state_q.rvalid;
  assign clockLaneEqualizerLevel = state_q.clkEq;
  assign dataLaneEqualizerLevel = state_q.dataEq;
  assign sideALowpowerSlew = state_q.sideASlew;
  assign sideBLowpowerSlew = state_q.sideBSlew;
  assign outputClockHighspeedSlew = state_q.hsClkSlew;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic readHit;
  logic writeHit;
  assign readHit = accessOk && !offsetLoad && !byteWrite && byteRead;
  assign writeHit = accessOk && !offsetLoad && byteWrite;

  sequence releaseSeq;
    state_q.phase == PH_IN_RESET && chipResetHigh ##1 state_q.phase == PH_LOAD;
  endsequence

  sequence strapTaken;
    state_q.phase == PH_LOAD && chipResetHigh;
  endsequence

  a_rev_read: assert property (
    readHit && state_q.ptr == OFS_SILICON_REVISION |=> readValid && readData == SILICON_REVISION)
    else $error("revision byte read wrong");

  a_strap_eq_load: assert property (
    strapTaken |=> clockLaneEqualizerLevel == eqFromStrap($past(eqStrap))
      && dataLaneEqualizerLevel == clockLaneEqualizerLevel)
    else $error("equalizer strap not loaded");

  a_release_order: assert property (
    releaseSeq |=> state_q.phase == PH_RUN || state_q.phase == PH_IN_RESET)
    else $error("strap load not single cycle");

  a_eq_sw_write: assert property (
    writeHit && state_q.ptr == OFS_RX_EQUALIZER |=> clockLaneEqualizerLevel ==
      $past(writeData[3:2]) && dataLaneEqualizerLevel == $past(writeData[1:0]))
    else $error("equalizer write lost");

  a_slew_sw_write: assert property (
    writeHit && state_q.ptr == OFS_TX_EDGE_RATE |=> {sideALowpowerSlew, sideBLowpowerSlew,
      outputClockHighspeedSlew} == {$past(writeData[7:4]), $past(writeData[1:0])})
    else $error("edge rate write lost");

  a_side_a_default: assert property (
    strapTaken |=> sideALowpowerSlew == LP_SLEW_18NS)
    else $error("side-A slew default wrong");

  a_hs_strap_range: assert property (
    strapTaken |=> outputClockHighspeedSlew != 2'h3 && sideBLowpowerSlew != 2'h3)
    else $error("strap produced software-only code");

  a_ptr_advance: assert property (
    (readHit || writeHit) && chipResetHigh |=> state_q.ptr == $past(state_q.ptr) + 8'h01
      || state_q.phase == PH_IN_RESET)
    else $error("offset did not advance");

  a_reserved_zero: assert property (
    readHit && state_q.ptr == OFS_TX_EDGE_RATE |=> readData[3:2] == 2'h0)
    else $error("reserved bits not zero");

  a_no_resample: assert property (
    state_q.phase == PH_RUN && chipResetHigh && !writeHit |=> $stable(clockLaneEqualizerLevel)
      && $stable(outputClockHighspeedSlew))
    else $error("field changed without write");
endmodule

// >>> hdl/rtr_pkg.sv
// constants shared by the retimer tuning register bank
package rtr_pkg;
  // register offsets (byte addresses on the two-wire register port)
  localparam logic [7:0] OFS_SILICON_REVISION = 8'h08;
  localparam logic [7:0] OFS_RX_EQUALIZER = 8'h09;
  localparam logic [7:0] OFS_TX_EDGE_RATE = 8'h0A;
  // offset pointer value after reset
  localparam logic [7:0] PTR_RESET = 8'h00;
  // field positions, equalizer register
  localparam int CLK_EQ_LSB = 2;
  localparam int DATA_EQ_LSB = 0;
  // field positions, edge-rate register
  localparam int SIDE_A_SLEW_LSB = 6;
  localparam int SIDE_B_SLEW_LSB = 4;
  localparam int HS_CLK_SLEW_LSB = 0;
  // field reset values
  localparam logic [1:0] FIELD_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // encoding of a three-level strap pin as delivered by the pad detector
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  // equalizer codes: 0 dB, 2.5 dB, 5 dB (2'h2 is reserved)
  localparam logic [1:0] EQ_0DB = 2'h0;
  localparam logic [1:0] EQ_2P5DB = 2'h1;
  localparam logic [1:0] EQ_5DB = 2'h3;
  // high-speed slew codes: 200 ps, 150 ps, 250 ps; 300 ps (2'h3) by software only
  localparam logic [1:0] HS_SLEW_200PS = 2'h0;
  localparam logic [1:0] HS_SLEW_150PS = 2'h1;
  localparam logic [1:0] HS_SLEW_250PS = 2'h2;
  // low-power slew codes: 18 ns default, 21 ns, 15 ns, 27 ns
  localparam logic [1:0] LP_SLEW_18NS = 2'h0;
  localparam logic [1:0] LP_SLEW_21NS = 2'h1;
  localparam logic [1:0] LP_SLEW_15NS = 2'h2;
  // pin synchroniser width: chip reset, eq strap, edge strap, config strap
  localparam int SYNC_WIDTH = 7;
  // life cycle of the bank around the chip reset pin
  typedef enum logic [1:0] {PH_IN_RESET, PH_LOAD, PH_RUN} rtr_phase_e;
endpackage

// >>> hdl/rtr_pin_sync.sv
// three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module rtr_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinStable
);
  import rtr_pkg::*;

  // whole synchroniser state
  typedef struct packed {
    logic [WIDTH-1:0] s1; // first stage, read only by the second
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable; // last value on which s2 and s3 agreed
  } rtr_sync_s;

  rtr_sync_s state_q;
  rtr_sync_s state_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.s1 = pinIn;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    // per bit: only a value seen twice in a row is taken, filtering one-cycle glitches
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_q.s2[i] == state_q.s3[i])
      begin
        state_d.stable[i] = state_q.s3[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pinStable = state_q.stable;
endmodule

// >>> verif/rtr_host_model.sv
// host-side model that issues byte-port requests to the tuning register bank
`timescale 1ns/1ps
module rtr_host_model (
  input wire logic mclk,
  input wire logic chipResetN,
  input wire logic [7:0] readData,
  input wire logic readValid,
  output logic offsetLoad,
  output logic [7:0] offsetIn,
  output logic byteWrite,
  output logic [7:0] writeData,
  output logic byteRead
);
  // idle levels from time zero
  initial
  begin
    offsetLoad = 1'b0;
    offsetIn = 8'h00;
    byteWrite = 1'b0;
    writeData = 8'h00;
    byteRead = 1'b0;
  end

  // ----------------------------------------
  // request: kind 0 offset, 1 write, 2 read
  // ----------------------------------------
  // the strobe stands for exactly one sampling edge, then data lines show
  // the inverse so a stale value is never mistaken for a live one
  task request(input logic [1:0] kind, input logic [7:0] val);
    @(posedge mclk);
    // the host keeps off the port while the chip is held in reset
    if (chipResetN === 1'b1)
    begin
      offsetLoad <= (kind == 2'h0);
      byteWrite <= (kind == 2'h1);
      byteRead <= (kind == 2'h2);
      offsetIn <= val;
      writeData <= val;
    end
    @(posedge mclk);
    offsetLoad <= 1'b0;
    byteWrite <= 1'b0;
    byteRead <= 1'b0;
    offsetIn <= ~val;
    writeData <= ~val;
  endtask

  // read one byte; the answer is awaited for a bounded number of edges
  task read_byte(output logic [7:0] rd, output logic ok);
    request(2'h2, 8'h00);
    ok = 1'b0;
    rd = 8'h00;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      #1;
      if (readValid === 1'b1)
      begin
        rd = readData;
        ok = 1'b1;
      end
      else
        @(posedge mclk);
    end
  endtask
endmodule

// >>> verif/rtr_tuning_registers_bench.sv
// self-checking bench for the retimer tuning register bank
`timescale 1ns/1ps
module rtr_tuning_registers_bench;
  import rtr_pkg::*;
  // revision value is arbitrary
  localparam logic [7:0] REV = 8'h5A;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic chipResetN = 1'b0;
  logic [1:0] eqStrap = STRAP_MID;
  logic [1:0] edgeStrap = STRAP_HIGH;
  logic [1:0] cfgStrap = STRAP_MID;
  logic offsetLoad;
  logic [7:0] offsetIn;
  logic byteWrite;
  logic [7:0] writeData;
  logic byteRead;
  logic [7:0] readData;
  logic readValid;
  logic [1:0] clkEq, dataEq, slewA, slewB, slewHs;
  wire logic [9:0] fields = {clkEq, dataEq, slewA, slewB, slewHs};
  int errors = 0;
  int nCompared = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic ok;
  logic [1:0] k;

  always #4 mclk = ~mclk;

  rtr_tuning_registers #(.SILICON_REVISION(REV)) rtr_tuning_registers_inst (
    .mclk(mclk), .reset(reset), .chipResetN(chipResetN),
    .eqStrapLevel(eqStrap), .edgeStrapLevel(edgeStrap), .cfgStrapLevel(cfgStrap),
    .offsetLoad(offsetLoad), .offsetIn(offsetIn), .byteWrite(byteWrite),
    .writeData(writeData), .byteRead(byteRead), .readData(readData),
    .readValid(readValid), .clockLaneEqualizerLevel(clkEq),
    .dataLaneEqualizerLevel(dataEq), .sideALowpowerSlew(slewA),
    .sideBLowpowerSlew(slewB), .outputClockHighspeedSlew(slewHs)
  );

  rtr_host_model rtr_host_model_inst (
    .mclk(mclk), .chipResetN(chipResetN), .readData(readData),
    .readValid(readValid), .offsetLoad(offsetLoad), .offsetIn(offsetIn),
    .byteWrite(byteWrite), .writeData(writeData), .byteRead(byteRead)
  );

  // verdict and end of run, reached from the main sequence or the watchdog
  task complete_run;
    $display("compared %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      complete_run();
    end
  end

  task check(input logic [9:0] got, input logic [9:0] exp);
    nCompared = nCompared + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read at the pointer; a missing answer shows up in bit 8
  task rd_chk(input logic [7:0] exp);
    rtr_host_model_inst.read_byte(rd, ok);
    check({1'b0, ok, rd}, {2'b01, exp});
    // the answer strobe lasts one cycle while the byte itself stays put
    @(posedge mclk);
    #1;
    check({1'b0, readValid, readData}, {2'h0, exp});
  endtask

  task go(input logic [7:0] ofs);
    rtr_host_model_inst.request(2'h0, ofs);
  endtask

  task wr(input logic [7:0] ofs, input logic [7:0] d);
    go(ofs);
    rtr_host_model_inst.request(2'h1, d);
  endtask

  // one spare edge lets a written field land before it is looked at
  task fld_chk(input logic [9:0] exp);
    @(posedge mclk);
    #1;
    check(fields, exp);
  endtask

  // chip reset pulse and release with the straps left at the levels the bench last set
  task chip_cycle;
    @(posedge mclk);
    chipResetN <= 1'b0;
    repeat (6) @(posedge mclk);
    fld_chk(10'h000);
    @(posedge mclk);
    chipResetN <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    chip_cycle();
    fld_chk(10'h146);
    eqStrap <= STRAP_HIGH;
    edgeStrap <= STRAP_LOW;
    cfgStrap <= STRAP_HIGH;
    repeat (6) @(posedge mclk);
    fld_chk(10'h146);
    $display("test strap load done");
    rd_chk(8'h00);
    go(OFS_SILICON_REVISION);
    rd_chk(REV);
    rd_chk(8'h05);
    rd_chk(8'h12);
    wr(OFS_SILICON_REVISION, 8'hFF);
    go(OFS_SILICON_REVISION);
    rd_chk(REV);
    $display("test read path done");
    // every code of every field, reserved bits written as ones
    for (int c = 0; c < 4; c++)
    begin
      k = c[1:0];
      wr(OFS_RX_EQUALIZER, {4'hF, k, k});
      go(OFS_RX_EQUALIZER);
      rd_chk({4'h0, k, k});
      wr(OFS_TX_EDGE_RATE, {k, k, 2'h3, k});
      go(OFS_TX_EDGE_RATE);
      rd_chk({k, k, 2'h0, k});
      fld_chk({k, k, k, k, k});
    end
    $display("test field codes done");
    // back-to-back writes walk the pointer across both registers
    go(OFS_RX_EQUALIZER);
    rtr_host_model_inst.request(2'h1, 8'h0E);
    rtr_host_model_inst.request(2'h1, 8'h41);
    fld_chk(10'h391);
    $display("test auto increment done");
    // the pointer wraps from the top offset back to zero and walks on
    go(8'hFF);
    repeat (9) rd_chk(8'h00);
    rd_chk(REV);
    $display("test pointer wrap done");
    chip_cycle();
    fld_chk(10'h3C8);
    go(OFS_RX_EQUALIZER);
    rd_chk(8'h0F);
    rd_chk(8'h20);
    $display("test strap reload done");
    // remaining strap levels: equalizer low, edge mid, config low
    @(posedge mclk);
    eqStrap <= STRAP_LOW;
    edgeStrap <= STRAP_MID;
    cfgStrap <= STRAP_LOW;
    chip_cycle();
    fld_chk(10'h001);
    go(OFS_RX_EQUALIZER);
    rd_chk(8'h00);
    rd_chk(8'h01);
    $display("test strap levels done");
    complete_run();
  end
endmodule
